// >>> cisb_status_bank.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module cisb_status_bank
  import cisb_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // system clock events, one-cycle pulses
  input  wire logic              sys_unlocked_evt,
  input  wire logic              sys_stable_evt,
  input  wire logic              sys_locked_evt,
  input  wire logic              sys_cal_off_evt,
  input  wire logic              sys_cal_on_evt,
  input  wire logic              wdog_timeout_evt,
  input  wire logic              nvm_fault_evt,
  input  wire logic              nvm_done_evt,
  // compensation loop, skew and temperature events
  input  wire logic              skew_limit_evt,
  input  wire logic              temp_warn_evt,
  input  wire logic              loop_unfault_evt,
  input  wire logic              loop_fault_evt,
  input  wire logic              loop_unlock_evt,
  input  wire logic              loop_lock_evt,
  // reference events, one nibble per input:
  // bit 3 resync, 2 validated, 1 unfaulted, 0 faulted
  input  wire logic [3:0]        first_a_side_reference_evt,
  input  wire logic [3:0]        second_a_side_reference_evt,
  input  wire logic [3:0]        first_b_side_reference_evt,
  input  wire logic [3:0]        second_b_side_reference_evt,
  // timestamp and oscillator events
  input  wire logic              skew_updated_evt,
  input  wire logic              ts_unit1_evt,
  input  wire logic              ts_unit0_evt,
  input  wire logic              nco1_evt,
  input  wire logic              nco0_evt,
  // clear strobes from the separate clear logic
  input  wire logic [REG_W-1:0]  clear_system_clock,
  input  wire logic [REG_W-1:0]  clear_aux_loop,
  input  wire logic [REG_W-1:0]  clear_a_side_reference,
  input  wire logic [REG_W-1:0]  clear_b_side_reference,
  input  wire logic [REG_W-1:0]  clear_timestamp,
  // status towards the mask logic
  output logic      [REG_W-1:0]  system_clock_event_status,
  output logic      [REG_W-1:0]  aux_loop_event_status,
  output logic      [REG_W-1:0]  a_side_reference_event_status,
  output logic      [REG_W-1:0]  b_side_reference_event_status,
  output logic      [REG_W-1:0]  timestamp_event_status
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0]    evt_vec [NUM_REGS];  // event per slot
  logic [REG_W-1:0]    clr_vec [NUM_REGS];  // clear per slot
  logic [REG_W-1:0]    flg_vec [NUM_REGS];  // flags per slot
  logic                rd_setup;            // read setup cycle
  logic                any_setup;           // any setup cycle
  logic                bus_access;          // access phase
  logic [NUM_REGS-1:0] reg_sel;             // one-hot select
  logic                reg_hit;             // mapped address
  logic [REG_W-1:0]    rd_mux;              // selected flags
  logic [DATA_W-1:0]   prdata_reg;          // captured data
  logic [DATA_W-1:0]   prdata_next;
  logic                pslverr_reg;         // captured error
  logic                pslverr_next;
  logic                unused_wdata;        // write data ignored
  logic [REG_W-1:0]    aux_kept;            // uncleared loop flags

  // ----------------------------------------------------------------
  // event packing into register layout
  // ----------------------------------------------------------------
  // system clock register
  always_comb
  begin
    evt_vec[SLOT_SYS]                    = STATUS_RESET;
    evt_vec[SLOT_SYS][SYS_UNLOCKED_BIT]  = sys_unlocked_evt;
    evt_vec[SLOT_SYS][SYS_STABLE_BIT]    = sys_stable_evt;
    evt_vec[SLOT_SYS][SYS_LOCKED_BIT]    = sys_locked_evt;
    evt_vec[SLOT_SYS][SYS_CAL_OFF_BIT]   = sys_cal_off_evt;
    evt_vec[SLOT_SYS][SYS_CAL_ON_BIT]    = sys_cal_on_evt;
    evt_vec[SLOT_SYS][SYS_WDOG_BIT]      = wdog_timeout_evt;
    evt_vec[SLOT_SYS][SYS_NVM_FAULT_BIT] = nvm_fault_evt;
    evt_vec[SLOT_SYS][SYS_NVM_DONE_BIT]  = nvm_done_evt;
  end

  // compensation loop register; bits 7:6 stay zero
  always_comb
  begin
    evt_vec[SLOT_AUX]                   = STATUS_RESET;
    evt_vec[SLOT_AUX][AUX_SKEW_LIM_BIT] = skew_limit_evt;
    evt_vec[SLOT_AUX][AUX_TEMP_BIT]     = temp_warn_evt;
    evt_vec[SLOT_AUX][AUX_UNFAULT_BIT]  = loop_unfault_evt;
    evt_vec[SLOT_AUX][AUX_FAULT_BIT]    = loop_fault_evt;
    evt_vec[SLOT_AUX][AUX_UNLOCK_BIT]   = loop_unlock_evt;
    evt_vec[SLOT_AUX][AUX_LOCK_BIT]     = loop_lock_evt;
  end

  // reference registers: second input high nibble, first low
  always_comb
  begin
    evt_vec[SLOT_A] = {second_a_side_reference_evt,
                       first_a_side_reference_evt};
    evt_vec[SLOT_B] = {second_b_side_reference_evt,
                       first_b_side_reference_evt};
  end

  // timestamp register; bits 7:5 stay zero
  always_comb
  begin
    evt_vec[SLOT_TS]                  = STATUS_RESET;
    evt_vec[SLOT_TS][TS_SKEW_UPD_BIT] = skew_updated_evt;
    evt_vec[SLOT_TS][TS_UNIT1_BIT]    = ts_unit1_evt;
    evt_vec[SLOT_TS][TS_UNIT0_BIT]    = ts_unit0_evt;
    evt_vec[SLOT_TS][TS_NCO1_BIT]     = nco1_evt;
    evt_vec[SLOT_TS][TS_NCO0_BIT]     = nco0_evt;
  end

  // clear strobes in slot order
  assign clr_vec[SLOT_SYS] = clear_system_clock;
  assign clr_vec[SLOT_AUX] = clear_aux_loop;
  assign clr_vec[SLOT_A]   = clear_a_side_reference;
  assign clr_vec[SLOT_B]   = clear_b_side_reference;
  assign clr_vec[SLOT_TS]  = clear_timestamp;

  // ----------------------------------------------------------------
  // flag banks
  // ----------------------------------------------------------------
  // masks tie off reserved bits so they can never read as one
  cisb_flag_bank #(.IMPL_MASK(SYS_MASK)) u_sys_flags (
    .clk      (clk),
    .reset_n  (reset_n),
    .events   (evt_vec[SLOT_SYS]),
    .clears   (clr_vec[SLOT_SYS]),
    .flags    (flg_vec[SLOT_SYS])
  );

  cisb_flag_bank #(.IMPL_MASK(AUX_MASK)) u_aux_flags (
    .clk      (clk),
    .reset_n  (reset_n),
    .events   (evt_vec[SLOT_AUX]),
    .clears   (clr_vec[SLOT_AUX]),
    .flags    (flg_vec[SLOT_AUX])
  );

  cisb_flag_bank #(.IMPL_MASK(REF_MASK)) u_a_flags (
    .clk      (clk),
    .reset_n  (reset_n),
    .events   (evt_vec[SLOT_A]),
    .clears   (clr_vec[SLOT_A]),
    .flags    (flg_vec[SLOT_A])
  );

  cisb_flag_bank #(.IMPL_MASK(REF_MASK)) u_b_flags (
    .clk      (clk),
    .reset_n  (reset_n),
    .events   (evt_vec[SLOT_B]),
    .clears   (clr_vec[SLOT_B]),
    .flags    (flg_vec[SLOT_B])
  );

  cisb_flag_bank #(.IMPL_MASK(TS_MASK)) u_ts_flags (
    .clk      (clk),
    .reset_n  (reset_n),
    .events   (evt_vec[SLOT_TS]),
    .clears   (clr_vec[SLOT_TS]),
    .flags    (flg_vec[SLOT_TS])
  );

  // status outputs come straight from the flag flops
  assign system_clock_event_status     = flg_vec[SLOT_SYS];
  assign aux_loop_event_status         = flg_vec[SLOT_AUX];
  assign a_side_reference_event_status = flg_vec[SLOT_A];
  assign b_side_reference_event_status = flg_vec[SLOT_B];
  assign timestamp_event_status        = flg_vec[SLOT_TS];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  cisb_apb_port u_apb (
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .rd_setup  (rd_setup),
    .any_setup (any_setup),
    .access    (bus_access),
    .reg_sel   (reg_sel),
    .hit       (reg_hit)
  );

  // read select; an unmapped address yields zero
  assign rd_mux =
    reg_sel[SLOT_SYS] ? flg_vec[SLOT_SYS] :
    reg_sel[SLOT_AUX] ? flg_vec[SLOT_AUX] :
    reg_sel[SLOT_A]   ? flg_vec[SLOT_A]   :
    reg_sel[SLOT_B]   ? flg_vec[SLOT_B]   :
    reg_sel[SLOT_TS]  ? flg_vec[SLOT_TS]  : STATUS_RESET;

  // data captured at setup so the access cycle shows a flop;
  // a flag set during the access cycle shows on the next read
  assign prdata_next  = rd_setup ? {24'h000000, rd_mux} : prdata_reg;
  // error for any unmapped access; writes to mapped addresses
  // complete cleanly and change nothing
  assign pslverr_next = any_setup ? ~reg_hit : pslverr_reg;
  // write data have no destination: every register is read-only
  assign unused_wdata = |pwdata;

  // read data and error registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'h0;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // zero wait states; error only qualifies the access phase
  assign pready  = 1'h1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & bus_access;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // loop flags that no clear touched must still stand next cycle
  assign aux_kept = aux_loop_event_status & ~clear_aux_loop;

  sys_lock_a:
    assert property (sys_unlocked_evt && sys_locked_evt |=>
      system_clock_event_status[SYS_UNLOCKED_BIT] &&
      system_clock_event_status[SYS_LOCKED_BIT])
    else $error("system clock lock flags not set");

  sys_cal_a:
    assert property (sys_cal_on_evt |=>
      system_clock_event_status[SYS_CAL_ON_BIT] ##0
      $past(sys_cal_off_evt) ==
      system_clock_event_status[SYS_CAL_OFF_BIT] ||
      $past(system_clock_event_status[SYS_CAL_OFF_BIT]))
    else $error("calibration flags wrong");

  sys_misc_a:
    assert property (wdog_timeout_evt && nvm_done_evt |=>
      (system_clock_event_status & 8'h05) == 8'h05)
    else $error("watchdog or memory flag not set");

  aux_reserved_a:
    assert property ((aux_loop_event_status[7:6] == 2'h0) and
      (temp_warn_evt |=> aux_loop_event_status[AUX_TEMP_BIT]))
    else $error("loop register reserved or temp bit wrong");

  loop_flags_a:
    assert property (loop_fault_evt |=>
      aux_loop_event_status[AUX_FAULT_BIT])
    else $error("loop fault flag not set");

  ref_a_high_a:
    assert property (second_a_side_reference_evt != 4'h0 |=>
      (a_side_reference_event_status[7:4] &
       $past(second_a_side_reference_evt)) ==
      $past(second_a_side_reference_evt))
    else $error("second a-side flags not set");

  ref_a_low_a:
    assert property (first_a_side_reference_evt[REF_FAULT_BIT] |=>
      a_side_reference_event_status[REF_FAULT_BIT])
    else $error("first a-side fault flag not set");

  ref_b_high_a:
    assert property (second_b_side_reference_evt[REF_RESYNC_BIT] |=>
      b_side_reference_event_status[REF_RESYNC_BIT + REF_SECOND_OFS])
    else $error("second b-side resync flag not set");

  ref_b_low_a:
    assert property (first_b_side_reference_evt[REF_VALID_BIT] |=>
      b_side_reference_event_status[REF_VALID_BIT])
    else $error("first b-side valid flag not set");

  ts_reserved_a:
    assert property ((timestamp_event_status[7:5] == 3'h0) and
      (skew_updated_evt |=> timestamp_event_status[TS_SKEW_UPD_BIT]))
    else $error("timestamp reserved or skew bit wrong");

  ts_units_a:
    assert property (ts_unit1_evt |=>
      timestamp_event_status[TS_UNIT1_BIT])
    else $error("timestamp unit flag not set");

  nco_events_a:
    assert property (nco0_evt |=> timestamp_event_status[TS_NCO0_BIT])
    else $error("oscillator flag not set");

  flag_hold_a:
    assert property (1'h1 |=>
      ((aux_loop_event_status & $past(aux_kept)) == $past(aux_kept)))
    else $error("flag dropped without a clear");

  clear_wins_a:
    assert property (clear_timestamp[TS_NCO1_BIT] && !nco1_evt |=>
      !timestamp_event_status[TS_NCO1_BIT])
    else $error("flag survived its clear");

  read_back_a:
    assert property (rd_setup && reg_sel[SLOT_A] |=>
      bus_access && prdata == {24'h000000,
      $past(a_side_reference_event_status)} && !pslverr)
    else $error("read data not the captured flags");

  unmapped_a:
    assert property (any_setup && !reg_hit ##1 bus_access |->
      pslverr && pready)
    else $error("unmapped access not flagged");
endmodule

// >>> cisb_pkg.sv
package cisb_pkg;
  // ----------------------------------------------------------------
  // bus and register geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int REG_W    = 8;
  localparam int NUM_REGS = 5;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] SYSTEM_CLOCK_IDX = 16'h300B;
  localparam logic [ADDR_W-1:0] AUX_LOOP_IDX     = 16'h300C;
  localparam logic [ADDR_W-1:0] A_SIDE_REF_IDX   = 16'h300D;
  localparam logic [ADDR_W-1:0] B_SIDE_REF_IDX   = 16'h300E;
  localparam logic [ADDR_W-1:0] TIMESTAMP_IDX    = 16'h300F;

  // slot of each register in the internal arrays
  localparam int SLOT_SYS = 0;
  localparam int SLOT_AUX = 1;
  localparam int SLOT_A   = 2;
  localparam int SLOT_B   = 3;
  localparam int SLOT_TS  = 4;

  // reset value and implemented bits of each status register
  localparam logic [REG_W-1:0] STATUS_RESET   = 8'h00;
  localparam logic [REG_W-1:0] SYS_MASK       = 8'hFF;
  localparam logic [REG_W-1:0] AUX_MASK       = 8'h3F;
  localparam logic [REG_W-1:0] REF_MASK       = 8'hFF;
  localparam logic [REG_W-1:0] TS_MASK        = 8'h1F;

  // system clock register fields
  localparam int SYS_UNLOCKED_BIT  = 7;
  localparam int SYS_STABLE_BIT    = 6;
  localparam int SYS_LOCKED_BIT    = 5;
  localparam int SYS_CAL_OFF_BIT   = 4;
  localparam int SYS_CAL_ON_BIT    = 3;
  localparam int SYS_WDOG_BIT      = 2;
  localparam int SYS_NVM_FAULT_BIT = 1;
  localparam int SYS_NVM_DONE_BIT  = 0;
  // compensation loop register fields
  localparam int AUX_SKEW_LIM_BIT  = 5;
  localparam int AUX_TEMP_BIT      = 4;
  localparam int AUX_UNFAULT_BIT   = 3;
  localparam int AUX_FAULT_BIT     = 2;
  localparam int AUX_UNLOCK_BIT    = 1;
  localparam int AUX_LOCK_BIT      = 0;
  // reference fields, within a nibble; second input sits high
  localparam int REF_RESYNC_BIT    = 3;
  localparam int REF_VALID_BIT     = 2;
  localparam int REF_UNFAULT_BIT   = 1;
  localparam int REF_FAULT_BIT     = 0;
  localparam int REF_SECOND_OFS    = 4;
  // timestamp register fields
  localparam int TS_SKEW_UPD_BIT   = 4;
  localparam int TS_UNIT1_BIT      = 3;
  localparam int TS_UNIT0_BIT      = 2;
  localparam int TS_NCO1_BIT       = 1;
  localparam int TS_NCO0_BIT       = 0;

  // one-hot register select from a byte address, zero when unmapped
  function automatic logic [NUM_REGS-1:0] cisb_reg_select
    (input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = {2'h0, addr[ADDR_W-1:2]};
    if (addr[1:0] != 2'h0)
      cisb_reg_select = 5'h00;
    else if (idx == SYSTEM_CLOCK_IDX)
      cisb_reg_select = 5'h01;
    else if (idx == AUX_LOOP_IDX)
      cisb_reg_select = 5'h02;
    else if (idx == A_SIDE_REF_IDX)
      cisb_reg_select = 5'h04;
    else if (idx == B_SIDE_REF_IDX)
      cisb_reg_select = 5'h08;
    else if (idx == TIMESTAMP_IDX)
      cisb_reg_select = 5'h10;
    else
      cisb_reg_select = 5'h00;
  endfunction
endpackage

// >>> cisb_flag_bank.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// sticky event flags of one status register
// ------------------------------------------------------------------
module cisb_flag_bank
  import cisb_pkg::*;
#(
  parameter logic [REG_W-1:0] IMPL_MASK = 8'hFF
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // event pulses and clear strobes
  input  wire logic [REG_W-1:0] events,
  input  wire logic [REG_W-1:0] clears,
  // flag state
  output logic      [REG_W-1:0] flags
);
  logic [REG_W-1:0] flag_reg;   // held flags
  logic [REG_W-1:0] flag_next;  // next flag value

  genvar i;
  generate
    for (i = 0; i < REG_W; i++)
    begin : g_bit
      // set beats clear so an event in the clear cycle survives;
      // reserved bits are tied off and read as zero
      assign flag_next[i] = IMPL_MASK[i] &
        (events[i] | (flag_reg[i] & ~clears[i]));
    end
  endgenerate

  // flag storage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_reg <= STATUS_RESET;
    else
      flag_reg <= flag_next;
  end

  assign flags = flag_reg;
endmodule

// >>> cisb_apb_port.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// apb decode: zero wait, read strobe in the setup cycle
// ------------------------------------------------------------------
module cisb_apb_port
  import cisb_pkg::*;
(
  // apb request
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  // decoded request
  output logic                   rd_setup,
  output logic                   any_setup,
  output logic                   access,
  output logic      [NUM_REGS-1:0] reg_sel,
  output logic                   hit
);
  assign reg_sel   = cisb_reg_select(paddr);
  assign hit       = |reg_sel;
  // setup cycle: data are captured here so they leave a flop
  assign any_setup = psel & ~penable;
  assign rd_setup  = any_setup & ~pwrite;
  // access cycle always completes, slave never stalls
  assign access    = psel & penable;
endmodule

// >>> cisb_status_bank_tb_top.sv
`timescale 1ns/1ps
module cisb_status_bank_tb_top
  import cisb_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk;         // 50 MHz bench clock
  logic              reset_n;     // async reset, low active
  logic              psel;        // apb select
  logic              penable;     // apb access phase
  logic              pwrite;      // apb direction
  logic [ADDR_W-1:0] paddr;       // apb byte address
  logic [DATA_W-1:0] pwdata;      // apb write data
  logic [DATA_W-1:0] prdata;      // apb read data
  logic              pready;      // apb ready
  logic              pslverr;     // apb error
  logic [39:0]       evt;         // all event inputs, 8 per register
  logic [39:0]       clr;         // all clear strobes, 8 per register
  wire  [39:0]       stat;        // all status outputs, 8 per register
  int                num_errors;  // mismatches seen
  int                compares;    // comparisons made
  // implemented bits; reserved ones must never set
  logic [7:0]        impl_mask [0:4] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h1F};

  // ----------------------------------------------------------------
  // clock and design
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  cisb_status_bank dut (
    .clk                           (clk),
    .reset_n                       (reset_n),
    .psel                          (psel),
    .penable                       (penable),
    .pwrite                        (pwrite),
    .paddr                         (paddr),
    .pwdata                        (pwdata),
    .prdata                        (prdata),
    .pready                        (pready),
    .pslverr                       (pslverr),
    .sys_unlocked_evt              (evt[7]),
    .sys_stable_evt                (evt[6]),
    .sys_locked_evt                (evt[5]),
    .sys_cal_off_evt               (evt[4]),
    .sys_cal_on_evt                (evt[3]),
    .wdog_timeout_evt              (evt[2]),
    .nvm_fault_evt                 (evt[1]),
    .nvm_done_evt                  (evt[0]),
    .skew_limit_evt                (evt[13]),
    .temp_warn_evt                 (evt[12]),
    .loop_unfault_evt              (evt[11]),
    .loop_fault_evt                (evt[10]),
    .loop_unlock_evt               (evt[9]),
    .loop_lock_evt                 (evt[8]),
    .first_a_side_reference_evt    (evt[19:16]),
    .second_a_side_reference_evt   (evt[23:20]),
    .first_b_side_reference_evt    (evt[27:24]),
    .second_b_side_reference_evt   (evt[31:28]),
    .skew_updated_evt              (evt[36]),
    .ts_unit1_evt                  (evt[35]),
    .ts_unit0_evt                  (evt[34]),
    .nco1_evt                      (evt[33]),
    .nco0_evt                      (evt[32]),
    .clear_system_clock            (clr[7:0]),
    .clear_aux_loop                (clr[15:8]),
    .clear_a_side_reference        (clr[23:16]),
    .clear_b_side_reference        (clr[31:24]),
    .clear_timestamp               (clr[39:32]),
    .system_clock_event_status     (stat[7:0]),
    .aux_loop_event_status         (stat[15:8]),
    .a_side_reference_event_status (stat[23:16]),
    .b_side_reference_event_status (stat[31:24]),
    .timestamp_event_status        (stat[39:32])
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte address is four times the printed index
  function automatic logic [15:0] reg_addr(input int r);
    return (16'h300B + 16'(r)) << 2;
  endfunction

  // word-wide comparison
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single-flag comparison
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd, output logic [31:0] d,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle event and clear strobes, then let the flag update land
  task automatic pulse(input logic [39:0] e, input logic [39:0] c);
    @(posedge clk);
    evt <= e;
    clr <= c;
    @(posedge clk);
    evt <= '0;
    clr <= '0;
    #1;
  endtask

  // set each bit of one register, then write, hold, read and clear
  task automatic walk_reg(input int r);
    logic [7:0]  exp;
    logic [31:0] d;
    logic        e;
    exp = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      pulse(40'h1 << (r * 8 + b), '0);
      exp[b] = impl_mask[r][b];
      chk_data({24'h0, stat[r*8 +: 8]}, {24'h0, exp});
    end
    // writing ones must leave the flags alone and raise no error;
    // ones also catch a clear-on-write slave
    apb(1'b1, reg_addr(r), 32'h000000FF, d, e);
    chk_bit(e, 1'b0);
    repeat (5) @(posedge clk);
    apb(1'b0, reg_addr(r), 32'h0, d, e);
    chk_data(d, {24'h0, impl_mask[r]});
    chk_bit(e, 1'b0);
    pulse('0, 40'hFF << (r * 8));
    apb(1'b0, reg_addr(r), 32'h0, d, e);
    chk_data(d, 32'h0);
  endtask

  // verdict; the single place where the run ends
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: tests need well under 1000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [31:0] d;
    logic        e;
    clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    evt = '0;
    clr = '0;
    num_errors = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // reset values of the whole bank
    for (int r = 0; r < 5; r++)
    begin
      apb(1'b0, reg_addr(r), 32'h0, d, e);
      chk_data(d, 32'h0);
    end
    walk_reg(0);
    walk_reg(1);
    walk_reg(2);
    walk_reg(3);
    walk_reg(4);
    // event and clear in the same cycle: set must win
    pulse(40'h1 << 32, 40'h1 << 32);
    chk_bit(stat[32], 1'b1);
    pulse('0, 40'h1 << 32);
    chk_bit(stat[32], 1'b0);
    // unmapped and misaligned accesses are refused
    apb(1'b0, 16'hC040, 32'h0, d, e);
    chk_bit(e, 1'b1);
    chk_data(d, 32'h0);
    chk_bit(pready, 1'b1);
    apb(1'b0, 16'hC02D, 32'h0, d, e);
    chk_bit(e, 1'b1);
    apb(1'b1, 16'hC028, 32'hFFFFFFFF, d, e);
    chk_bit(e, 1'b1);
    // every implemented flag at once, then a mid-run reset wipes them
    pulse('1, '0);
    chk_data(stat[31:0], 32'hFFFF3FFF);
    chk_data({24'h0, stat[39:32]}, 32'h0000001F);
    // let the multi-flag checks finish before reset disables them
    repeat (2) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk_data({24'h0, stat[7:0]}, 32'h0);
    apb(1'b0, reg_addr(3), 32'h0, d, e);
    chk_data(d, 32'h0);
    summarize();
  end
endmodule
